// File: design/dsb_debug_regs.sv
`timescale 1ns/1ps
module dsb_debug_regs (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire dsb_pkg::dsb_req_s req,
  input  wire dsb_pkg::dsb_cpu_s cpu,
  input  wire logic             resume,
  output logic [15:0]           rdata_r,
  output logic                  rvalid_r,
  output logic                  halt_active_r,
  output logic                  halt_req_r,
  output logic                  swi_req_r,
  output logic                  tag_req_r,
  output logic                  link_clock_select_r,
  output logic                  intrusive_ok_r
);
  // reset release through two flops
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  logic        halt_permit_r;
  logic        bkpt_enable_r;
  logic        force_tag_r;
  logic        ws_latched_r;
  logic        ws_fail_r;
  logic [15:0] bkpt_addr_r;
  logic        hit;
  logic        force_pend_r;

  // command decode
  wire wr_ctrl  = req.cmd == dsb_pkg::DSB_CMD_WRITE_CTRL;
  wire rd_stat  = req.cmd == dsb_pkg::DSB_CMD_READ_STAT;
  wire wr_bkpt  = req.cmd == dsb_pkg::DSB_CMD_BREAKPOINT_WRITE_CMD;
  wire rd_bkpt  = req.cmd == dsb_pkg::DSB_CMD_BREAKPOINT_READ_CMD;
  wire force_hc = req.cmd == dsb_pkg::DSB_CMD_FORCE_HALT;

  // breakpoint comparator
  dsb_bkpt_match #(.AW(dsb_pkg::ADDR_W)) u_match (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (bkpt_enable_r),
    .cpu_addr  (cpu.addr),
    .bkpt_addr (bkpt_addr_r),
    .hit_r     (hit)
  );

  // breakpoint dispatch: force waits for boundary, tag marks fetch
  wire force_hit  = hit && bkpt_enable_r && force_tag_r;
  wire tag_hit    = hit && bkpt_enable_r && !force_tag_r && cpu.opcode_fetch;
  // pending force dropped when disabled or already halted
  wire force_pend_nxt = (force_pend_r || force_hit) && !cpu.insn_boundary && bkpt_enable_r
                      && !halt_active_r;
  wire bkpt_fire  = (force_pend_r || force_hit) && cpu.insn_boundary && bkpt_enable_r;
  wire tag_fire   = cpu.queue_end_tag && bkpt_enable_r;
  wire brk_event  = (bkpt_fire || tag_fire) && !halt_active_r;
  wire halt_enter = (brk_event || force_hc) && halt_permit_r;
  wire swi_nxt    = brk_event && !halt_permit_r;

  // halt state: entered by breakpoint or forcing command, left on resume
  wire halt_nxt = halt_enter ? 1'b1 : (resume ? 1'b0 : halt_active_r);
  // wait/stop flag: live state, or latched when forced out of wait/stop
  wire ws_latch_nxt = (force_hc && halt_permit_r && cpu.wait_stop) ? 1'b1
                    : (resume ? 1'b0 : ws_latched_r);
  // failure flag sticky; set wins over clear on resume
  wire ws_fail_nxt = cpu.mem_fail_ws ? 1'b1 : (resume ? 1'b0 : ws_fail_r);
  // halt_permit sticky until reset; write refused while halted
  wire permit_nxt = halt_permit_r
                  || (wr_ctrl && !halt_active_r && req.wdata[dsb_pkg::BIT_HALT_PERMIT]);

  // status byte; bit 2 also takes live cpu.wait_stop, bit 0 reads zero
  wire [7:0] status_byte = {halt_permit_r, halt_active_r, bkpt_enable_r, force_tag_r,
                            link_clock_select_r, ws_latched_r || cpu.wait_stop,
                            ws_fail_r, 1'b0};
  wire [15:0] rdata_nxt = rd_stat ? {8'h00, status_byte}
                        : (rd_bkpt ? bkpt_addr_r : rdata_r);

  // control bits, permit and breakpoint register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_permit_r       <= dsb_pkg::CTRL_RESET[dsb_pkg::BIT_HALT_PERMIT];
      bkpt_enable_r       <= dsb_pkg::CTRL_RESET[dsb_pkg::BIT_BKPT_ENABLE];
      force_tag_r         <= dsb_pkg::CTRL_RESET[dsb_pkg::BIT_FORCE_TAG];
      link_clock_select_r <= dsb_pkg::CTRL_RESET[dsb_pkg::BIT_LINK_CLK_SEL];
      bkpt_addr_r         <= dsb_pkg::BKPT_RESET;
    end else begin
      halt_permit_r <= permit_nxt;
      if (wr_ctrl) begin
        bkpt_enable_r       <= req.wdata[dsb_pkg::BIT_BKPT_ENABLE];
        force_tag_r         <= req.wdata[dsb_pkg::BIT_FORCE_TAG];
        link_clock_select_r <= req.wdata[dsb_pkg::BIT_LINK_CLK_SEL];
      end
      if (wr_bkpt) begin
        bkpt_addr_r <= req.wdata;
      end
    end
  end

  // halt, status flags and breakpoint requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_active_r <= 1'b0;
      ws_latched_r  <= 1'b0;
      ws_fail_r     <= 1'b0;
      force_pend_r  <= 1'b0;
      halt_req_r    <= 1'b0;
      swi_req_r     <= 1'b0;
      tag_req_r     <= 1'b0;
    end else begin
      halt_active_r <= halt_nxt;
      ws_latched_r  <= ws_latch_nxt;
      ws_fail_r     <= ws_fail_nxt;
      force_pend_r  <= force_pend_nxt;
      halt_req_r    <= halt_enter;
      swi_req_r     <= swi_nxt;
      tag_req_r     <= tag_hit;
    end
  end

  // read data and permission outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r        <= 16'h0000;
      rvalid_r       <= 1'b0;
      intrusive_ok_r <= 1'b0;
    end else begin
      rdata_r        <= rdata_nxt;
      rvalid_r       <= rd_stat || rd_bkpt;
      intrusive_ok_r <= halt_nxt && halt_permit_r;
    end
  end

  chk_permit_locked: assert property (@(posedge clk) disable iff (!rst_n)
    halt_active_r && wr_ctrl |=> halt_permit_r == $past(halt_permit_r))
    else $error("permit changed while halted");
  chk_permit_hold: assert property (@(posedge clk) disable iff (!rst_n)
    halt_permit_r |=> halt_permit_r)
    else $error("permit cleared without reset");
  chk_no_bkpt_off: assert property (@(posedge clk) disable iff (!rst_n)
    !bkpt_enable_r ##1 !bkpt_enable_r |-> !tag_req_r)
    else $error("tag request while breakpoint disabled");
  chk_force_halt: assert property (@(posedge clk) disable iff (!rst_n)
    force_hc && halt_permit_r && !resume |=> halt_active_r && halt_req_r)
    else $error("forcing command did not halt");
  chk_swi_path: assert property (@(posedge clk) disable iff (!rst_n)
    bkpt_fire && !halt_active_r && !halt_permit_r |=> swi_req_r && !halt_req_r)
    else $error("no software interrupt on unpermitted break");
  chk_force_brk: assert property (@(posedge clk) disable iff (!rst_n)
    bkpt_fire && halt_permit_r && !halt_active_r && !resume |=> halt_active_r)
    else $error("force breakpoint did not halt");
  chk_ws_fail: assert property (@(posedge clk) disable iff (!rst_n)
    cpu.mem_fail_ws |=> ws_fail_r)
    else $error("wait/stop failure not flagged");
  chk_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stat |=> rvalid_r && rdata_r[0] == 1'b0 && rdata_r[6] == $past(halt_active_r))
    else $error("status read wrong");
  chk_ws_bit: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stat && cpu.wait_stop |=> rdata_r[2])
    else $error("wait/stop bit not shown");
  chk_clk_sel: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> link_clock_select_r == $past(req.wdata[3]))
    else $error("clock select not written");
endmodule

// File: shared/dsb_pkg.sv
package dsb_pkg;
  // status/control bit positions
  localparam int unsigned BIT_HALT_PERMIT    = 7;
  localparam int unsigned BIT_HALT_ACTIVE    = 6;
  localparam int unsigned BIT_BKPT_ENABLE    = 5;
  localparam int unsigned BIT_FORCE_TAG      = 4;
  localparam int unsigned BIT_LINK_CLK_SEL   = 3;
  localparam int unsigned BIT_WAIT_STOP      = 2;
  localparam int unsigned BIT_WAIT_STOP_FAIL = 1;
  localparam int unsigned BIT_SLOW_FAIL      = 0;
  // reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
  localparam int unsigned ADDR_W     = 16;

  // serial command decode presented by the protocol engine
  typedef enum logic [2:0] {
    DSB_CMD_NONE       = 3'b000,
    DSB_CMD_READ_STAT  = 3'b001,
    DSB_CMD_WRITE_CTRL = 3'b010,
    DSB_CMD_BREAKPOINT_READ_CMD  = 3'b011,
    DSB_CMD_BREAKPOINT_WRITE_CMD = 3'b100,
    DSB_CMD_FORCE_HALT = 3'b101
  } dsb_cmd_e;

  // one serial command with its write data
  typedef struct packed {
    dsb_cmd_e    cmd;
    logic [15:0] wdata;
  } dsb_req_s;

  // cpu side status
  typedef struct packed {
    logic        wait_stop;
    logic        mem_fail_ws;
    logic        insn_boundary;
    logic        opcode_fetch;
    logic        queue_end_tag;
    logic [15:0] addr;
  } dsb_cpu_s;
endpackage

// File: design/dsb_bkpt_match.sv
`timescale 1ns/1ps
// address comparator for the breakpoint register
module dsb_bkpt_match #(
  parameter int unsigned AW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          enable,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [AW-1:0] bkpt_addr,
  output logic               hit_r
);
  // full-width equality each bus cycle, gated by enable
  wire hit_nxt = enable && (cpu_addr == bkpt_addr);

  // registered hit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  chk_hit_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
    hit_r |-> $past(enable) && $past(cpu_addr) == $past(bkpt_addr))
    else $error("hit without enabled address match");
endmodule

// File: testbench/dsb_host_model.sv
`timescale 1ns/1ps
// debug host: each serial command held one cycle, changed on the falling edge
module dsb_host_model (
  input  wire logic         clk,
  input  wire logic [15:0]  rdata_r,
  input  wire logic         rvalid_r,
  output dsb_pkg::dsb_req_s req
);
  initial req = '{dsb_pkg::DSB_CMD_NONE, 16'h0000};
  // one command cycle, then idle with the released data toggled
  task automatic send(input dsb_pkg::dsb_cmd_e c, input logic [15:0] w);
    @(negedge clk);
    req = '{c, w};
    @(negedge clk);
    req = '{dsb_pkg::DSB_CMD_NONE, ~w};
  endtask
  // read command; answer taken at the falling edge that releases it
  task automatic rd(input dsb_pkg::dsb_cmd_e c, output logic [15:0] d, output logic v);
    send(c, 16'h0000);
    d = rdata_r;
    v = rvalid_r;
  endtask
  task automatic rd_stat(output logic [15:0] d, output logic v);
    rd(dsb_pkg::DSB_CMD_READ_STAT, d, v);
  endtask
  task automatic wr_ctrl(input logic [15:0] w);
    send(dsb_pkg::DSB_CMD_WRITE_CTRL, w);
  endtask
  // breakpoint programmed before the program runs
  task automatic wr_bkpt(input logic [15:0] w);
    send(dsb_pkg::DSB_CMD_BREAKPOINT_WRITE_CMD, w);
  endtask
  // force halt, confirm halt active before anything else
  task automatic halt_confirm(output logic ok);
    logic [15:0] d;
    logic        v;
    send(dsb_pkg::DSB_CMD_FORCE_HALT, 16'h0000);
    rd_stat(d, v);
    ok = v & d[6];
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
// self-checking bench for the debug status and breakpoint registers
module tb;
  logic              clk, rstn, resume, v, ok;
  logic              rvalid_r, halt_active_r, halt_req_r, swi_req_r, tag_req_r;
  logic              link_clock_select_r, intrusive_ok_r;
  logic [15:0]       rdata_r, d, hit_addr;
  logic [2:0]        p;
  dsb_pkg::dsb_req_s req;
  dsb_pkg::dsb_cpu_s cpu;
  int                fail_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  // rows: control and breakpoint word, expected status, expected clock select
  logic [24:0]       rows [3] = '{{16'hffff, 8'hb8, 1'h1}, {16'h5a30, 8'hb0, 1'h0}, {16'h0000, 8'h80, 1'h0}};
  dsb_debug_regs dut (.clk(clk), .rstn(rstn), .req(req), .cpu(cpu), .resume(resume), .rdata_r(rdata_r),
    .rvalid_r(rvalid_r), .halt_active_r(halt_active_r), .halt_req_r(halt_req_r), .swi_req_r(swi_req_r),
    .tag_req_r(tag_req_r), .link_clock_select_r(link_clock_select_r), .intrusive_ok_r(intrusive_ok_r));
  dsb_host_model host (.clk(clk), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .req(req));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // collect halt, interrupt and tag pulses over n cycles
  task automatic seen(input int n, output logic [2:0] acc);
    acc = 3'h0;
    repeat (n) begin
      @(negedge clk);
      acc = acc | {halt_req_r, swi_req_r, tag_req_r};
    end
  endtask
  task automatic go_on();
    @(negedge clk);
    resume = 1'h1;
    @(negedge clk);
    resume = 1'h0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  // main sequence
  initial begin
    rstn = 1'h0;
    resume = 1'h0;
    cpu = '0;
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    repeat (3) @(negedge clk);
    host.rd_stat(d, v);
    chk(16'(v), 16'h0001, "rvalid");
    chk(d, 16'h0000, "stat rst");
    chk(16'(link_clock_select_r), 16'h0000, "clksel rst");
    host.rd(dsb_pkg::DSB_CMD_BREAKPOINT_READ_CMD, d, v);
    chk(d, 16'h0000, "bkpt rst");
    foreach (rows[i]) begin
      host.wr_ctrl(rows[i][24:9]);
      host.wr_bkpt(rows[i][24:9]);
      host.rd_stat(d, v);
      chk(d, {8'h00, rows[i][8:1]}, "stat row");
      chk(16'(link_clock_select_r), 16'(rows[i][0]), "clksel");
      host.rd(dsb_pkg::DSB_CMD_BREAKPOINT_READ_CMD, d, v);
      chk(d, rows[i][24:9], "bkpt row");
    end
    // mid-run reset: only a reset clears the permit; outputs low two edges
    rstn = 1'h0;
    @(negedge clk);
    rstn = 1'h1;
    repeat (2) begin
      @(negedge clk);
      chk(rdata_r, 16'h0000, "rdata after rst");
      chk(16'({rvalid_r, halt_active_r, halt_req_r, swi_req_r, tag_req_r, link_clock_select_r, intrusive_ok_r}),
          16'h0000, "outs after rst");
    end
    host.rd_stat(d, v);
    chk(d, 16'h0000, "permit cleared");
    // no permit: forced halt refused, match gives software interrupt
    host.wr_bkpt(16'hc35a);
    host.wr_ctrl(16'h0030);
    host.rd(dsb_pkg::DSB_CMD_BREAKPOINT_READ_CMD, hit_addr, v);
    chk(hit_addr, 16'hc35a, "bkpt set");
    host.halt_confirm(ok);
    chk(16'(ok), 16'h0000, "halt no permit");
    cpu.insn_boundary = 1'h1;
    cpu.addr = hit_addr ^ 16'h8000;
    seen(5, p);
    chk(16'(p), 16'h0000, "near addr");
    cpu.addr = hit_addr;
    seen(5, p);
    chk(16'(p), 16'h0002, "swi");
    // enable clear: match and a late queue tag ignored
    cpu.addr = 16'h0000;
    host.wr_ctrl(16'h0090);
    cpu.addr = hit_addr;
    cpu.queue_end_tag = 1'h1;
    @(negedge clk);
    cpu.queue_end_tag = 1'h0;
    seen(5, p);
    chk(16'(p), 16'h0000, "bkpt off");
    chk(16'(halt_active_r), 16'h0000, "tag off");
    // force select waits for an instruction boundary
    cpu.insn_boundary = 1'h0;
    host.wr_ctrl(16'h00b0);
    seen(5, p);
    chk(16'(p), 16'h0000, "no boundary");
    cpu.insn_boundary = 1'h1;
    seen(3, p);
    chk(16'(p), 16'h0004, "force halt");
    cpu.addr = 16'h0000;
    chk(16'(intrusive_ok_r), 16'h0001, "intrusive");
    host.wr_ctrl(16'h0008);
    host.rd_stat(d, v);
    chk(d, 16'h00c8, "stat halted");
    go_on();
    host.rd_stat(d, v);
    chk(d, 16'h0088, "stat run");
    // tag select: halt only when the tag leaves the queue
    host.wr_ctrl(16'h00a0);
    cpu.opcode_fetch = 1'h1;
    cpu.addr = hit_addr;
    seen(4, p);
    cpu.opcode_fetch = 1'h0;
    cpu.addr = 16'h0000;
    chk(16'(p), 16'h0001, "tag only");
    cpu.queue_end_tag = 1'h1;
    @(negedge clk);
    cpu.queue_end_tag = 1'h0;
    seen(2, p);
    chk(16'(halt_active_r), 16'h0001, "tag halt");
    go_on();
    // wait/stop with a failed access, then forced recovery
    cpu.wait_stop = 1'h1;
    cpu.mem_fail_ws = 1'h1;
    @(negedge clk);
    cpu.mem_fail_ws = 1'h0;
    host.rd_stat(d, v);
    chk(d, 16'h00a6, "ws fail");
    host.halt_confirm(ok);
    chk(16'(ok), 16'h0001, "forced ws");
    cpu.wait_stop = 1'h0;
    host.rd_stat(d, v);
    chk(d, 16'h00e6, "ws latched");
    go_on();
    host.rd_stat(d, v);
    chk(d, 16'h00a0, "ws cleared");
    close_out();
  end
endmodule
